// ==== rtl/uras_pkg.sv ====
package uras_pkg;

  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned CNT_W    = 17;
  localparam logic [2:0] A_FCR     = 3'h0; // format_control_register
  localparam logic [2:0] A_CVR     = 3'h1; // compare_value_register
  localparam logic [2:0] A_BPR     = 3'h2; // break_parity_register
  localparam logic [2:0] A_ISR     = 3'h3; // interrupt_status_register
  localparam logic [2:0] A_IMR     = 3'h4; // interrupt mask
  localparam logic [2:0] A_RXD     = 3'h5; // received data
  localparam int unsigned RATE_LO  = 0;
  localparam int unsigned RATE_HI  = 3;
  localparam int unsigned FMT_BIT  = 6;
  localparam int unsigned PAR_BIT  = 0;
  localparam int unsigned ST_FULL  = 0;
  localparam int unsigned ST_ERRC  = 1;
  localparam int unsigned ST_PAR   = 2;
  localparam logic [3:0] RATE_EXT  = 4'hf;
  localparam logic [7:0] FCR_RST   = 8'h00;
  localparam logic [7:0] ZERO8     = 8'h00;
  localparam logic [3:0] EXT_DIV   = 4'hf; // divide by sixteen, count 15..0

  typedef logic [CNT_W-1:0] uras_cnt_t;

  function automatic uras_cnt_t uras_divisor(input logic [3:0] sel);
    unique case (sel)
      4'h0: uras_divisor = 17'd73728;
      4'h1: uras_divisor = 17'd33538;
      4'h2: uras_divisor = 17'd27408;
      4'h3: uras_divisor = 17'd24576;
      4'h4: uras_divisor = 17'd12288;
      4'h5: uras_divisor = 17'd6144;
      4'h6: uras_divisor = 17'd3072;
      4'h7: uras_divisor = 17'd2048;
      4'h8: uras_divisor = 17'd1536;
      4'h9: uras_divisor = 17'd1024;
      4'ha: uras_divisor = 17'd768;
      4'hb: uras_divisor = 17'd512;
      4'hc: uras_divisor = 17'd384;
      4'hd: uras_divisor = 17'd192;
      4'he: uras_divisor = 17'd96;
      4'hf: uras_divisor = 17'd16;
    endcase
  endfunction

endpackage

// ==== rtl/uras_sync.sv ====
`timescale 1ns/1ps
module uras_sync
  import uras_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_en,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // change counts once second and third stage agree
  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else if (clock_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level_out <= 1'b1;
    end else if (clock_en && (s2_q == s3_q)) begin
      level_out <= s3_q;
    end
  end

  assign rise_out = clock_en && (s2_q == s3_q) && s3_q && !level_out;

endmodule

// ==== rtl/uras_top.sv ====
`timescale 1ns/1ps
module uras_top
  import uras_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              clock_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  input  wire logic              transmit_external_clock,
  input  wire logic              receive_external_clock,
  input  wire logic              rx_done,
  input  wire logic [7:0]        rx_char,
  input  wire logic              rx_is_addr,
  input  wire logic              rx_parity,
  input  wire logic              rx_error,
  output logic                   baud_tick,
  output logic                   compare_mode,
  output logic                   irq
);

  // ****************************************************************
  // register writes
  // ****************************************************************
  logic [7:0] fcr_q;
  logic [7:0] cvr_q;
  logic       par_sel_q;
  logic [7:0] mask_q;
  logic [7:0] rxd_q;
  logic       cmp_q;
  logic [2:0] isr_q;

  logic wr_fcr;
  logic wr_cvr;
  logic wr_bpr;
  logic wr_isr;
  assign wr_fcr = wr_stb && clock_en && (addr == A_FCR);
  // compare register only reachable when bit 6 clear
  assign wr_cvr = wr_stb && clock_en && (addr == A_CVR) && !fcr_q[FMT_BIT];
  assign wr_bpr = wr_stb && clock_en && (addr == A_BPR);
  assign wr_isr = wr_stb && clock_en && (addr == A_ISR);

  always_ff @(posedge clock) begin
    if (reset) begin
      fcr_q <= FCR_RST;
    end else if (wr_fcr) begin
      fcr_q <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cvr_q <= ZERO8;
    end else if (wr_cvr) begin
      cvr_q <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      par_sel_q <= 1'b0;
    end else if (wr_bpr) begin
      par_sel_q <= wdata[PAR_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mask_q <= ZERO8;
    end else if (wr_stb && clock_en && (addr == A_IMR)) begin
      mask_q <= wdata;
    end
  end

  // ****************************************************************
  // baud generator
  // ****************************************************************
  logic [3:0] rate_sel;
  logic       ext_rise;
  logic       tx_ext_lvl;
  logic       tx_ext_rise;
  logic       rx_ext_lvl;
  logic       rx_ext_rise;
  uras_cnt_t  cnt_q;

  assign rate_sel = fcr_q[RATE_HI:RATE_LO];

  uras_sync u_sync_tx (
    .clock     (clock),
    .reset     (reset),
    .clock_en  (clock_en),
    .async_in  (transmit_external_clock),
    .level_out (tx_ext_lvl),
    .rise_out  (tx_ext_rise)
  );

  uras_sync u_sync_rx (
    .clock     (clock),
    .reset     (reset),
    .clock_en  (clock_en),
    .async_in  (receive_external_clock),
    .level_out (rx_ext_lvl),
    .rise_out  (rx_ext_rise)
  );

  // either external clock edge counts toward the divide by sixteen
  assign ext_rise = tx_ext_rise || rx_ext_rise;

  // crystal divisors: 73,728 / 33,538 / 27,408 / 24,576 / ... / 96
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q     <= uras_divisor(FCR_RST[RATE_HI:RATE_LO]) - 17'd1;
      baud_tick <= 1'b0;
    end else if (clock_en) begin
      baud_tick <= 1'b0;
      if (wr_fcr && (wdata[RATE_HI:RATE_LO] != rate_sel)) begin
        cnt_q <= uras_divisor(wdata[RATE_HI:RATE_LO]) - 17'd1;
      end else if (rate_sel == RATE_EXT) begin
        if (ext_rise) begin
          if (cnt_q[3:0] == 4'h0) begin
            cnt_q     <= {13'h0000, EXT_DIV};
            baud_tick <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 17'd1;
          end
        end
      end else if (cnt_q == '0) begin
        cnt_q     <= uras_divisor(rate_sel) - 17'd1;
        baud_tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 17'd1;
      end
    end
  end

  // ****************************************************************
  // address recognition
  // ****************************************************************
  logic match;
  assign match = rx_done && rx_is_addr && (rx_char == cvr_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      cmp_q <= 1'b0;
    end else if (clock_en) begin
      if (wr_cvr) begin
        cmp_q <= 1'b1;
      end else if (cmp_q && match) begin
        cmp_q <= 1'b0;
      end
    end
  end
  assign compare_mode = cmp_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      rxd_q <= ZERO8;
    end else if (clock_en && rx_done && !cmp_q) begin
      rxd_q <= rx_char;
    end
  end

  // ****************************************************************
  // interrupt status: set wins over write-one clear
  // ****************************************************************
  logic [2:0] set_v;
  logic [2:0] clr_v;
  always_comb begin
    set_v = 3'h0;
    // full flag inhibited in compare mode
    set_v[ST_FULL] = rx_done && !cmp_q;
    // bit1 set on entry and held while comparing; match raises interrupt
    set_v[ST_ERRC] = wr_cvr || (cmp_q && !match) || (cmp_q && match) || (!cmp_q && rx_done && rx_error);
    set_v[ST_PAR]  = rx_done && !cmp_q && (par_sel_q ? rx_parity : rx_error);
    clr_v = wr_isr ? wdata[2:0] : 3'h0;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      isr_q <= 3'h0;
    end else if (clock_en) begin
      isr_q <= (isr_q & ~clr_v) | set_v;
    end
  end

  // in compare mode only the match itself may reach the host
  logic [2:0] irq_src;
  assign irq_src = cmp_q ? 3'h0 : (isr_q & mask_q[2:0]);

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clock_en) begin
      irq <= |irq_src || (cmp_q && match && mask_q[ST_ERRC]);
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= ZERO8;
    end else if (clock_en) begin
      rdata <= ZERO8;
      if (rd_stb) begin
        unique case (addr)
          A_FCR:   rdata <= fcr_q;
          A_ISR:   rdata <= {5'h00, isr_q};
          A_IMR:   rdata <= mask_q;
          A_RXD:   rdata <= rxd_q;
          default: rdata <= ZERO8;
        endcase
      end
    end
  end

endmodule

// ==== sim/uras_asserts.sv ====
`timescale 1ns/1ps
module uras_asserts
  import uras_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              clock_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [7:0]        rdata,
  input wire logic              rx_done,
  input wire logic [7:0]        rx_char,
  input wire logic              rx_is_addr,
  input wire logic              baud_tick,
  input wire logic              compare_mode,
  input wire logic              irq
);
  localparam int DIV [15] = '{73728, 33538, 27408, 24576, 12288, 6144, 3072, 2048,
                              1536, 1024, 768, 512, 384, 192, 96};
  logic [7:0]  f_q, m_q, cv_q;
  logic [16:0] gap_q;
  logic [1:0]  ok_q;
  wire cvw = wr_stb && addr == A_CVR;
  wire hit = rx_done && rx_is_addr && rx_char == cv_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // shadow of the host writes; ok_q counts ticks since the last rate write, saturating at two
  always_ff @(posedge clock) begin
    gap_q <= baud_tick ? 17'h0 : gap_q + 17'h1;
    if (reset) begin
      f_q  <= FCR_RST;
      m_q  <= ZERO8;
      cv_q <= ZERO8;
      ok_q <= 2'h0;
    end else begin
      if (wr_stb && addr == A_FCR) f_q <= wdata;
      if (wr_stb && addr == A_IMR) m_q <= wdata;
      if (cvw && !f_q[FMT_BIT]) cv_q <= wdata;
      if (wr_stb && addr == A_FCR) ok_q <= 2'h0;
      else if (baud_tick && ok_q != 2'h2) ok_q <= ok_q + 2'h1;
    end
  end
  property p_div;
    baud_tick && ok_q == 2'h2 && f_q[3:0] != RATE_EXT |-> gap_q == DIV[f_q[3:0]] - 1;
  endproperty
  property p_tick; baud_tick |=> !baud_tick; endproperty
  property p_enter; cvw && !f_q[FMT_BIT] |=> compare_mode; endproperty
  property p_refuse; cvw && f_q[FMT_BIT] && !compare_mode |=> !compare_mode; endproperty
  property p_hold; compare_mode && !hit |=> compare_mode; endproperty
  property p_leave; compare_mode && hit && !cvw |=> !compare_mode; endproperty
  property p_irq; compare_mode && hit && !cvw && m_q[ST_ERRC] |=> irq; endproperty
  property p_quiet; compare_mode && $past(compare_mode) |-> !irq; endproperty
  a_div: assert property (p_div) else $error("wrong divisor");
  a_tick: assert property (p_tick) else $error("long tick");
  a_enter: assert property (p_enter) else $error("no compare");
  a_refuse: assert property (p_refuse) else $error("write taken");
  a_hold: assert property (p_hold) else $error("left early");
  a_leave: assert property (p_leave) else $error("stayed");
  a_irq: assert property (p_irq) else $error("no irq");
  a_quiet: assert property (p_quiet) else $error("irq in compare");
  c_match: cover property (compare_mode ##1 !compare_mode);
  c_irq: cover property ($rose(irq));
  c_ext: cover property (baud_tick && f_q[3:0] == RATE_EXT);
endmodule
bind uras_top uras_asserts chk (
  .clock        (clock),
  .reset        (reset),
  .clock_en     (clock_en),
  .addr         (addr),
  .wdata        (wdata),
  .wr_stb       (wr_stb),
  .rd_stb       (rd_stb),
  .rdata        (rdata),
  .rx_done      (rx_done),
  .rx_char      (rx_char),
  .rx_is_addr   (rx_is_addr),
  .baud_tick    (baud_tick),
  .compare_mode (compare_mode),
  .irq          (irq)
);

// ==== sim/uras_partner.sv ====
`timescale 1ns/1ps
module uras_partner (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [7:0] ch,
  input  wire logic       ad,
  input  wire logic       par,
  output logic            rx_done,
  output logic      [7:0] rx_char,
  output logic            rx_is_addr,
  output logic            rx_parity,
  output logic            rx_error
);
  // fields turn over once the strobe has passed
  always_ff @(posedge clock) begin
    rx_done <= go;
    if (go) begin
      rx_char    <= ch;
      rx_is_addr <= ad;
      rx_parity  <= par;
      rx_error   <= 1'b0;
    end else if (rx_done) begin
      rx_char    <= ~rx_char;
      rx_is_addr <= ~rx_is_addr;
      rx_parity  <= ~rx_parity;
      rx_error   <= 1'b1;
    end
  end
endmodule

// ==== sim/uras_tb_top.sv ====
`timescale 1ns/1ps
module uras_tb_top;
  import uras_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t value mismatch", $time); end end
  logic              clock = 0, reset = 1, clock_en = 1, wr_stb = 0, rd_stb = 0;
  logic              go = 0, ad = 0, par = 0;
  logic              transmit_external_clock = 0, receive_external_clock = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = '0, ch = '0, rdata, rx_char;
  logic              rx_done, rx_is_addr, rx_parity, rx_error, baud_tick, compare_mode, irq;
  int                n_mismatch = 0, check_count = 0, n, i;
  int                div_tab [15] = '{73728, 33538, 27408, 24576, 12288, 6144, 3072, 2048,
                                      1536, 1024, 768, 512, 384, 192, 96};
  always #50 clock = ~clock;
  uras_top DUT (
    .clock                   (clock),
    .reset                   (reset),
    .clock_en                (clock_en),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr_stb                  (wr_stb),
    .rd_stb                  (rd_stb),
    .rdata                   (rdata),
    .transmit_external_clock (transmit_external_clock),
    .receive_external_clock  (receive_external_clock),
    .rx_done                 (rx_done),
    .rx_char                 (rx_char),
    .rx_is_addr              (rx_is_addr),
    .rx_parity               (rx_parity),
    .rx_error                (rx_error),
    .baud_tick               (baud_tick),
    .compare_mode            (compare_mode),
    .irq                     (irq)
  );
  uras_partner peer (
    .clock      (clock),
    .go         (go),
    .ch         (ch),
    .ad         (ad),
    .par        (par),
    .rx_done    (rx_done),
    .rx_char    (rx_char),
    .rx_is_addr (rx_is_addr),
    .rx_parity  (rx_parity),
    .rx_error   (rx_error)
  );
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic send(input logic [7:0] c, input logic a, input logic p);
    @(posedge clock);
    go <= 1'b1;
    ch <= c;
    ad <= a;
    par <= p;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic tk(output int t);
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (!baud_tick && t < 80000);
    if (t >= 80000) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rc(3'h7, ZERO8);
    rc(A_FCR, FCR_RST);
    for (i = 4; i < 15; i++) begin
      wr(A_FCR, i[7:0]);
      tk(n);
      tk(n);
      `CHK(n, div_tab[i])
    end
    wr(A_FCR, {4'h0, RATE_EXT});
    n = 0;
    for (i = 0; i < 160; i++) begin
      @(posedge clock);
      n += baud_tick;
      if (i % 4 == 0 && i < 80) transmit_external_clock <= ~transmit_external_clock;
      else if (i % 4 == 0) receive_external_clock <= ~receive_external_clock;
    end
    `CHK(n, 1)
    wr(A_IMR, 8'h02);
    wr(A_CVR, 8'h5a);
    `CHK(compare_mode, 1'b1)
    send(8'h33, 1'b1, 1'b0);
    send(8'h5a, 1'b0, 1'b0);
    `CHK(irq, 1'b0)
    rc(A_ISR, 8'h02);
    send(8'h5a, 1'b1, 1'b0);
    `CHK(compare_mode, 1'b0)
    `CHK(irq, 1'b1)
    send(8'ha5, 1'b0, 1'b0);
    rc(A_ISR, 8'h03);
    wr(A_ISR, 8'h03);
    rc(A_ISR, ZERO8);
    `CHK(irq, 1'b0)
    rc(A_RXD, 8'ha5);
    wr(A_BPR, 8'h01);
    send(8'h11, 1'b0, 1'b1);
    rc(A_ISR, 8'h05);
    wr(A_CVR, 8'h5a);
    `CHK(compare_mode, 1'b1)
    send(8'h5a, 1'b1, 1'b0);
    wr(A_FCR, 8'h4e);
    wr(A_CVR, 8'h5a);
    `CHK(compare_mode, 1'b0)
    // a write while the clock enable is low must be lost
    clock_en <= 1'b0;
    wr(A_IMR, 8'hff);
    clock_en <= 1'b1;
    rc(A_IMR, 8'h02);
    complete_run;
  end
endmodule
